// [verilog/cab_defines.vh]
// Constants for the cog ALU bit-field datapath: opcodes, field positions,
// shift amounts, flag-combine modes and generator constants.
// Assumes inclusion by bare name from the design files of this block.
//
// Summary of operation
// [RL1] Unsigned scale: D[15:0]*S[15:0] shifted right 16 becomes next source value.
// [RL2] Signed scale: signed 16x16 product shifted right 14 becomes next source.
// [RL3] Indexed insert writes S byte, nibble or word into field N of D.
// [RL4] Single-operand insert uses the field chosen by the prior index setup.
// [RL5] Dest-field insert puts S[8:0] into D[17:9], rest kept.
// [RL6] Result-field insert puts S[8:0] into D[27:19], rest kept.
// [RL7] Source-field insert puts S[8:0] into D[8:0], rest kept.
// [RL8] Forward and reverse scrambles are inverses; 32 steps restore the value.
// [RL9] Left shift by S[4:0], zero fill; carry is last bit out or D[31].
// [RL10] Right shift by S[4:0], zero fill; carry is last bit out or D[0].
// [RL11] Sign or zero extend D above bit S[4:0]; carry is result MSB.
// [RL12] Byte split gathers every fourth D bit into one result byte.
// [RL13] Word split puts odd bits in upper word, even bits in lower.
// [RL14] Subtract and reverse subtract; carry is borrow of the difference.
// [RL15] Signed subtract; carry is true sign of exact difference.
// [RL16] Extended subtracts include carry in; zero becomes old zero AND result zero.
// [RL17] Conditional sum subtracts when condition holds, else adds; carry is true sign.
// [RL18] Mask tests keep D; carry is parity, zero is all-clear of masked value.
// [RL19] Bit tests write, OR, AND or XOR D[S[4:0]], true or inverted, into a flag.
// [RL20] Flag stores write carry, not carry, zero or not zero into bit 0.
// [RL21] Exclusive-or stores D^S; carry is parity of result.
// [RL22] Random step advances D by xoroshiro32+ and feeds output as next source.
// [RL23] Every operation completes two core clocks after it is taken.
// [RL24] Flags change only when the matching write suffix is given.
`ifndef CAB_DEFINES_VH
`define CAB_DEFINES_VH

`define CAB_OP_W                     6
`define CAB_SCALE_UNSIGNED_OP        6'h00
`define CAB_SCALE_SIGNED_OP          6'h01
`define CAB_INSERT_BYTE_OP           6'h02
`define CAB_INSERT_NIBBLE_OP         6'h03
`define CAB_INSERT_HALFWORD_OP       6'h04
`define CAB_INSERT_DEST_FIELD_OP     6'h05
`define CAB_INSERT_RESULT_FIELD_OP   6'h06
`define CAB_INSERT_SOURCE_FIELD_OP   6'h07
`define CAB_SCRAMBLE_FORWARD_OP      6'h08
`define CAB_SCRAMBLE_REVERSE_OP      6'h09
`define CAB_LOGICAL_LEFT_SHIFT_OP    6'h0A
`define CAB_LOGICAL_RIGHT_SHIFT_OP   6'h0B
`define CAB_SIGN_EXTEND_OP           6'h0C
`define CAB_ZERO_EXTEND_OP           6'h0D
`define CAB_SPLIT_TO_BYTES_OP        6'h0E
`define CAB_SPLIT_TO_WORDS_OP        6'h0F
`define CAB_SUBTRACT_OP              6'h10
`define CAB_REVERSE_SUBTRACT_OP      6'h11
`define CAB_SIGNED_SUBTRACT_OP       6'h12
`define CAB_EXTENDED_SUBTRACT_OP     6'h13
`define CAB_SIGNED_EXTENDED_SUBTRACT_OP 6'h14
`define CAB_COND_SUM_ON_CARRY_OP     6'h15
`define CAB_COND_SUM_ON_NOCARRY_OP   6'h16
`define CAB_COND_SUM_ON_ZERO_OP      6'h17
`define CAB_COND_SUM_ON_NONZERO_OP   6'h18
`define CAB_MASK_PROBE_OP            6'h19
`define CAB_INVERTED_MASK_PROBE_OP   6'h1A
`define CAB_BIT_PROBE_OP             6'h1B
`define CAB_INVERTED_BIT_PROBE_OP    6'h1C
`define CAB_STORE_CARRY_OP           6'h1D
`define CAB_STORE_NOT_CARRY_OP       6'h1E
`define CAB_STORE_ZERO_FLAG_OP       6'h1F
`define CAB_STORE_NOT_ZERO_FLAG_OP   6'h20
`define CAB_XOR_OP                   6'h21
`define CAB_RANDOM_STEP_OP           6'h22

`define CAB_COMB_WRITE               2'h0
`define CAB_COMB_OR                  2'h1
`define CAB_COMB_AND                 2'h2
`define CAB_COMB_XOR                 2'h3

`define CAB_FIELD9_MASK              32'h000001FF
`define CAB_DEST_FIELD_LSB           5'h09
`define CAB_RESULT_FIELD_LSB         5'h13
`define CAB_SOURCE_FIELD_LSB         5'h00
`define CAB_BYTE_MASK                32'h000000FF
`define CAB_NIBBLE_MASK              32'h0000000F
`define CAB_HALFWORD_MASK            32'h0000FFFF
`define CAB_BYTE_POS_SHIFT           2'h3
`define CAB_NIBBLE_POS_SHIFT         2'h2
`define CAB_HALFWORD_POS_SHIFT       3'h4

`define CAB_SCALE_U_SHIFT            5'h10
`define CAB_SCALE_S_SHIFT            5'h0E

`define CAB_XORO_A                   4'hD
`define CAB_XORO_B                   4'h5
`define CAB_XORO_C                   4'hA
`define CAB_SCRAMBLE_MASK            32'h00000011

`define CAB_ZERO32                   32'h00000000
`define CAB_ONES32                   32'hFFFFFFFF
`define CAB_RESET_FLAG               1'b0

`endif

// [verilog/cab_scramble.v]
// Bit scrambler for the cog ALU: forward and reverse relocation patterns.
// Assumes a combinational caller that registers the result.
`timescale 1ns/100ps
`default_nettype none
`include "cab_defines.vh"

module cab_scramble (
	input  wire [31:0] value,
	input  wire        reverse,
	output wire [31:0] scrambled
);

////////////////////////////////////////////////////////////////////////////////
// Forward: rotate left one, then invert the mask bits.
// Reverse undoes it exactly. Mask weight is even, so the inversions
// cancel over a full turn and 32 steps give the value back.
wire [31:0] fwd;
wire [31:0] unmasked;
wire [31:0] rev;

assign fwd       = {value[30:0], value[31]} ^ `CAB_SCRAMBLE_MASK; // [RL8]
assign unmasked  = value ^ `CAB_SCRAMBLE_MASK;
assign rev       = {unmasked[0], unmasked[31:1]}; // [RL8]
assign scrambled = reverse ? rev : fwd;

endmodule
`default_nettype wire

// [verilog/cab_alu.v]
// Two-clock cog ALU datapath for bit-field, shift, subtract and test ops.
// Assumes the decoder presents one operation with start, already read
// operands, and the field index latched by any prior index setup.
`timescale 1ns/100ps
`default_nettype none
`include "cab_defines.vh"

module cab_alu #(
	parameter IDX_W = 3
) (
	input  wire                ref_clk,
	input  wire                rstn,
	input  wire                clk_en,
	input  wire                start,
	input  wire [`CAB_OP_W-1:0] op,
	input  wire [31:0]         dst,
	input  wire [31:0]         src,
	input  wire [IDX_W-1:0]    field_idx,
	input  wire                use_setup_idx,
	input  wire [IDX_W-1:0]    setup_idx,
	input  wire                carry_write_suffix,
	input  wire                zero_write_suffix,
	input  wire [1:0]          flag_combine,
	output reg                 done,
	output reg                 result_we,
	output reg  [31:0]         result,
	output reg                 next_src_valid,
	output reg  [31:0]         next_src,
	output reg                 carry_flag,
	output reg                 zero_flag
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function parity32;
	input [31:0] v;
	parity32 = ^v;
endfunction

// Add or subtract with carry in; bit 32 is borrow (unsigned) or true sign
function [32:0] arith33;
	input [31:0] a;
	input [31:0] b;
	input        neg;
	input        ci;
	input        sgn;
	reg   [32:0] ea;
	reg   [32:0] eb;
	begin
		ea = {sgn & a[31], a};
		eb = {sgn & b[31], b};
		if (neg) begin
			arith33 = ea - eb - {32'h00000000, ci};
		end else begin
			arith33 = ea + eb + {32'h00000000, ci};
		end
	end
endfunction

// Replace the masked field at pos with the low bits of v
function [31:0] insert32;
	input [31:0] d;
	input [31:0] v;
	input [31:0] mask;
	input [4:0]  pos;
	insert32 = (d & ~(mask << pos)) | ((v & mask) << pos);
endfunction

function combine;
	input       old;
	input       bitv;
	input [1:0] mode;
	begin
		case (mode)
			`CAB_COMB_OR:  combine = old | bitv;
			`CAB_COMB_AND: combine = old & bitv;
			`CAB_COMB_XOR: combine = old ^ bitv;
			default:       combine = bitv;
		endcase
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Stage one: capture the operation

reg                 s1_valid;
reg [`CAB_OP_W-1:0] s1_op;
reg [31:0]          s1_d;
reg [31:0]          s1_s;
reg [IDX_W-1:0]     s1_idx;
reg                 s1_wc;
reg                 s1_wz;
reg [1:0]           s1_comb;

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		s1_valid <= 1'b0;
		s1_op    <= `CAB_SCALE_UNSIGNED_OP;
		s1_d     <= `CAB_ZERO32;
		s1_s     <= `CAB_ZERO32;
		s1_idx   <= {IDX_W{1'b0}};
		s1_wc    <= 1'b0;
		s1_wz    <= 1'b0;
		s1_comb  <= `CAB_COMB_WRITE;
	end else if (clk_en) begin
		s1_valid <= start; // [RL23]
		if (start) begin
			s1_op   <= op;
			s1_d    <= dst;
			s1_s    <= src;
			s1_idx  <= use_setup_idx ? setup_idx : field_idx; // [RL4]
			s1_wc   <= carry_write_suffix;
			s1_wz   <= zero_write_suffix;
			s1_comb <= flag_combine;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Stage two: compute

wire [4:0]         sh = s1_s[4:0];
wire [31:0]        prod_u = s1_d[15:0] * s1_s[15:0];
wire signed [31:0] prod_s = $signed(s1_d[15:0]) * $signed(s1_s[15:0]);
wire [31:0]        scr_out;
wire [4:0]         byte_pos = {s1_idx[1:0], 3'h0};
wire [4:0]         nib_pos;
wire [4:0]         half_pos;
wire [32:0]        shl_w = {1'b0, s1_d} << sh;
wire [32:0]        shr_w = {s1_d, 1'b0} >> sh;
wire [31:0]        lo_mask = `CAB_ONES32 >> (~sh);
wire [15:0]        xs0 = s1_d[15:0];
wire [15:0]        xs1x = s1_d[31:16] ^ s1_d[15:0];

// Positions wrap at 32 bits; index bits above the field count drop out
assign nib_pos  = {s1_idx, 2'h0};
assign half_pos = {s1_idx[0], 4'h0};

cab_scramble u_scramble (
	.value     (s1_d),
	.reverse   (s1_op == `CAB_SCRAMBLE_REVERSE_OP),
	.scrambled (scr_out)
);

reg [31:0] next_res;
reg        next_we;
reg        next_c;
reg        next_z;
reg        c_ok;
reg        z_ok;
reg [31:0] next_ns;
reg        next_ns_v;
reg [32:0] ar;
reg        probe_bit;
integer    i;

// Ops that never touch a flag leave c_ok/z_ok low, so commit keeps them
always @* begin
	next_res  = s1_d;
	next_we   = 1'b1;
	next_c    = carry_flag;
	next_z    = zero_flag;
	c_ok      = 1'b0;
	z_ok      = 1'b0;
	next_ns   = `CAB_ZERO32;
	next_ns_v = 1'b0;
	ar        = 33'h000000000;
	probe_bit = s1_d[sh];
	case (s1_op)
		`CAB_SCALE_UNSIGNED_OP, `CAB_SCALE_SIGNED_OP: begin
			if (s1_op == `CAB_SCALE_SIGNED_OP) begin
				next_ns = prod_s >>> `CAB_SCALE_S_SHIFT; // [RL2]
			end else begin
				next_ns = prod_u >> `CAB_SCALE_U_SHIFT; // [RL1]
			end
			next_ns_v = 1'b1;
			next_we   = 1'b0;
			next_z    = (next_ns == `CAB_ZERO32);
			z_ok      = 1'b1;
		end
		`CAB_INSERT_BYTE_OP:
			next_res = insert32(s1_d, s1_s, `CAB_BYTE_MASK, byte_pos); // [RL3]
		`CAB_INSERT_NIBBLE_OP:
			next_res = insert32(s1_d, s1_s, `CAB_NIBBLE_MASK, nib_pos); // [RL3]
		`CAB_INSERT_HALFWORD_OP:
			next_res = insert32(s1_d, s1_s, `CAB_HALFWORD_MASK, half_pos); // [RL3]
		`CAB_INSERT_DEST_FIELD_OP:
			next_res = insert32(s1_d, s1_s, `CAB_FIELD9_MASK, `CAB_DEST_FIELD_LSB); // [RL5]
		`CAB_INSERT_RESULT_FIELD_OP:
			next_res = insert32(s1_d, s1_s, `CAB_FIELD9_MASK, `CAB_RESULT_FIELD_LSB); // [RL6]
		`CAB_INSERT_SOURCE_FIELD_OP:
			next_res = insert32(s1_d, s1_s, `CAB_FIELD9_MASK, `CAB_SOURCE_FIELD_LSB); // [RL7]
		`CAB_SCRAMBLE_FORWARD_OP, `CAB_SCRAMBLE_REVERSE_OP:
			next_res = scr_out; // [RL8]
		`CAB_LOGICAL_LEFT_SHIFT_OP: begin
			next_res     = shl_w[31:0]; // [RL9]
			next_c       = (sh == 5'h00) ? s1_d[31] : shl_w[32]; // [RL9]
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_LOGICAL_RIGHT_SHIFT_OP: begin
			next_res     = shr_w[32:1]; // [RL10]
			next_c       = (sh == 5'h00) ? s1_d[0] : shr_w[0]; // [RL10]
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_SIGN_EXTEND_OP, `CAB_ZERO_EXTEND_OP: begin
			if (probe_bit && s1_op == `CAB_SIGN_EXTEND_OP) begin
				next_res = s1_d | ~lo_mask; // [RL11]
			end else begin
				next_res = s1_d & lo_mask; // [RL11]
			end
			next_c       = next_res[31];
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_SPLIT_TO_BYTES_OP: begin
			for (i = 0; i < 32; i = i + 1) begin
				next_res[(i % 4) * 8 + i / 4] = s1_d[i]; // [RL12]
			end
		end
		`CAB_SPLIT_TO_WORDS_OP: begin
			for (i = 0; i < 16; i = i + 1) begin
				next_res[i + 16] = s1_d[2 * i + 1]; // [RL13]
				next_res[i]      = s1_d[2 * i];
			end
		end
		`CAB_SUBTRACT_OP, `CAB_REVERSE_SUBTRACT_OP, `CAB_SIGNED_SUBTRACT_OP: begin
			if (s1_op == `CAB_REVERSE_SUBTRACT_OP) begin
				ar = arith33(s1_s, s1_d, 1'b1, 1'b0, 1'b0); // [RL14]
			end else begin
				ar = arith33(s1_d, s1_s, 1'b1, 1'b0,
				             s1_op == `CAB_SIGNED_SUBTRACT_OP); // [RL14] [RL15]
			end
			next_res     = ar[31:0];
			next_c       = ar[32];
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_EXTENDED_SUBTRACT_OP, `CAB_SIGNED_EXTENDED_SUBTRACT_OP: begin
			ar = arith33(s1_d, s1_s, 1'b1, carry_flag,
			             s1_op == `CAB_SIGNED_EXTENDED_SUBTRACT_OP); // [RL16]
			next_res     = ar[31:0];
			next_c       = ar[32];
			next_z       = zero_flag & (ar[31:0] == `CAB_ZERO32); // [RL16]
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_COND_SUM_ON_CARRY_OP, `CAB_COND_SUM_ON_NOCARRY_OP,
		`CAB_COND_SUM_ON_ZERO_OP, `CAB_COND_SUM_ON_NONZERO_OP: begin
			case (s1_op)
				`CAB_COND_SUM_ON_CARRY_OP:   probe_bit = carry_flag;
				`CAB_COND_SUM_ON_NOCARRY_OP: probe_bit = ~carry_flag;
				`CAB_COND_SUM_ON_ZERO_OP:    probe_bit = zero_flag;
				default:                     probe_bit = ~zero_flag;
			endcase
			ar = arith33(s1_d, s1_s, probe_bit, 1'b0, 1'b1); // [RL17]
			next_res     = ar[31:0];
			next_c       = ar[32];
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_MASK_PROBE_OP, `CAB_INVERTED_MASK_PROBE_OP: begin
			// D-only form: decoder passes an all-ones source
			if (s1_op == `CAB_MASK_PROBE_OP) begin
				next_res = s1_d & s1_s;
			end else begin
				next_res = s1_d & ~s1_s;
			end
			next_c       = parity32(next_res); // [RL18]
			next_z       = (next_res == `CAB_ZERO32);
			next_we      = 1'b0;
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_BIT_PROBE_OP, `CAB_INVERTED_BIT_PROBE_OP: begin
			probe_bit    = s1_d[sh] ^ (s1_op == `CAB_INVERTED_BIT_PROBE_OP);
			next_c       = combine(carry_flag, probe_bit, s1_comb); // [RL19]
			next_z       = combine(zero_flag, probe_bit, s1_comb); // [RL19]
			next_we      = 1'b0;
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_STORE_CARRY_OP, `CAB_STORE_NOT_CARRY_OP,
		`CAB_STORE_ZERO_FLAG_OP, `CAB_STORE_NOT_ZERO_FLAG_OP: begin
			next_res = {31'h00000000,
			            (s1_op == `CAB_STORE_CARRY_OP)     ? carry_flag :
			            (s1_op == `CAB_STORE_NOT_CARRY_OP) ? ~carry_flag :
			            (s1_op == `CAB_STORE_ZERO_FLAG_OP) ? zero_flag : ~zero_flag}; // [RL20]
		end
		`CAB_XOR_OP: begin
			next_res     = s1_d ^ s1_s;
			next_c       = parity32(next_res); // [RL21]
			{c_ok, z_ok} = 2'h3;
		end
		`CAB_RANDOM_STEP_OP: begin
			// Low half is s0, high half is s1; output is the pre-step sum
			next_ns   = {16'h0000, xs0 + s1_d[31:16]}; // [RL22]
			next_ns_v = 1'b1;
			next_res[15:0]  = ((xs0 << `CAB_XORO_A) | (xs0 >> (5'h10 - `CAB_XORO_A)))
			                  ^ xs1x ^ (xs1x << `CAB_XORO_B); // [RL22]
			next_res[31:16] = (xs1x << `CAB_XORO_C) | (xs1x >> (5'h10 - `CAB_XORO_C));
		end
		default: begin
			next_we = 1'b0;
		end
	endcase
	if (c_ok && z_ok && next_we && s1_op != `CAB_EXTENDED_SUBTRACT_OP
	    && s1_op != `CAB_SIGNED_EXTENDED_SUBTRACT_OP) begin
		next_z = (next_res == `CAB_ZERO32);
	end
end

////////////////////////////////////////////////////////////////////////////////
// Stage two: commit

always @(posedge ref_clk or negedge rstn) begin
	if (!rstn) begin
		done           <= 1'b0;
		result_we      <= 1'b0;
		result         <= `CAB_ZERO32;
		next_src_valid <= 1'b0;
		next_src       <= `CAB_ZERO32;
		carry_flag     <= `CAB_RESET_FLAG;
		zero_flag      <= `CAB_RESET_FLAG;
	end else if (clk_en) begin
		done           <= s1_valid; // [RL23]
		result_we      <= s1_valid & next_we;
		next_src_valid <= s1_valid & next_ns_v;
		if (s1_valid) begin
			result   <= next_res;
			next_src <= next_ns;
			if (s1_wc && c_ok) begin
				carry_flag <= next_c; // [RL24]
			end
			if (s1_wz && z_ok) begin
				zero_flag <= next_z; // [RL24]
			end
		end
	end
end

endmodule
`default_nettype wire

// [test/cab_alu_props.sv]
// Checker for cab_alu: latency, pulse width, results and flag commits.
// Assumes it sees only the top ports; results are judged two edges after a take.
`timescale 1ns/100ps
`default_nettype none
`include "cab_defines.vh"

module cab_alu_props (
	input wire logic                  ref_clk,
	input wire logic                  rstn,
	input wire logic                  clk_en,
	input wire logic                  start,
	input wire logic [`CAB_OP_W-1:0]  op,
	input wire logic [31:0]           dst,
	input wire logic [31:0]           src,
	input wire logic                  carry_write_suffix,
	input wire logic                  zero_write_suffix,
	input wire logic                  done,
	input wire logic                  result_we,
	input wire logic [31:0]           result,
	input wire logic                  next_src_valid,
	input wire logic [31:0]           next_src,
	input wire logic                  carry_flag,
	input wire logic                  zero_flag
);
	wire       tk = start && clk_en;
	wire [4:0] sh = src[4:0];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	// A frozen cycle after the take is skipped, so clk_en gates every antecedent
	property p_lat;
		tk ##1 clk_en |=> done;
	endproperty
	a_lat: assert property (p_lat) else $error("done missing after take");
	property p_pulse;
		clk_en && !start ##1 clk_en |=> !done;
	endproperty
	a_pulse: assert property (p_pulse) else $error("done without take");
	property p_sub;
		tk && op == `CAB_SUBTRACT_OP ##1 clk_en |=>
			result_we && result == $past(dst, 2) - $past(src, 2);
	endproperty
	a_sub: assert property (p_sub) else $error("subtract result");
	property p_reverse_subtract_op;
		tk && op == `CAB_REVERSE_SUBTRACT_OP ##1 clk_en |=> result == $past(src, 2) - $past(dst, 2);
	endproperty
	a_reverse_subtract_op: assert property (p_reverse_subtract_op) else $error("reverse subtract result");
	property p_shl;
		tk && op == `CAB_LOGICAL_LEFT_SHIFT_OP ##1 clk_en |=> result == $past(dst, 2) << $past(sh, 2);
	endproperty
	a_shl: assert property (p_shl) else $error("left shift result");
	property p_shr;
		tk && op == `CAB_LOGICAL_RIGHT_SHIFT_OP ##1 clk_en |=> result == $past(dst, 2) >> $past(sh, 2);
	endproperty
	a_shr: assert property (p_shr) else $error("right shift result");
	property p_xor;
		tk && op == `CAB_XOR_OP && carry_write_suffix ##1 clk_en |=>
			result == ($past(dst, 2) ^ $past(src, 2)) && carry_flag == ^result;
	endproperty
	a_xor: assert property (p_xor) else $error("xor result or parity");
	property p_insert_dest_field_op;
		tk && op == `CAB_INSERT_DEST_FIELD_OP ##1 clk_en |=>
			result == (($past(dst, 2) & 32'hFFFC01FF) | (($past(src, 2) & 32'h000001FF) << 9));
	endproperty
	a_insert_dest_field_op: assert property (p_insert_dest_field_op) else $error("dest field insert");
	property p_scu;
		tk && op == `CAB_SCALE_UNSIGNED_OP ##1 clk_en |=> next_src_valid && !result_we &&
			next_src == ((($past(dst, 2) & 32'h0000FFFF) * ($past(src, 2) & 32'h0000FFFF)) >> 16);
	endproperty
	a_scu: assert property (p_scu) else $error("unsigned scale value");
	property p_probe;
		tk && (op == `CAB_MASK_PROBE_OP || op == `CAB_INVERTED_MASK_PROBE_OP ||
			op == `CAB_BIT_PROBE_OP || op == `CAB_INVERTED_BIT_PROBE_OP) ##1 clk_en |=> !result_we;
	endproperty
	a_probe: assert property (p_probe) else $error("probe wrote destination");
	property p_keep;
		tk && !carry_write_suffix && !zero_write_suffix ##1 clk_en |=>
			carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag);
	endproperty
	a_keep: assert property (p_keep) else $error("flags moved without suffix");
endmodule

bind cab_alu cab_alu_props u_props (.*);
`default_nettype wire

// [test/cab_src_model.sv]
// Decoder-side model: substitutes the fed-forward value as the next source.
// Assumes the bench presents the encoded source on src_req.
`timescale 1ns/100ps
`default_nettype none

module cab_src_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        clk_en,
	input  wire logic        start,
	input  wire logic [31:0] src_req,
	input  wire logic        next_src_valid,
	input  wire logic [31:0] next_src,
	output logic      [31:0] src
);
	logic        pending;
	logic [31:0] held;

	// Held until the next taken op consumes it; pulse alone is too short
	always @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pending <= 1'h0;
			held <= 32'h0;
		end else if (clk_en && next_src_valid) begin
			pending <= 1'h1;
			held <= next_src;
		end else if (clk_en && start) begin
			pending <= 1'h0;
		end
	end
	assign src = pending ? held : src_req;
endmodule
`default_nettype wire

// [test/cab_alu_tb.sv]
// Self-checking bench for cab_alu, one task per scenario.
// Assumes cab_src_model feeds the source port and cab_alu_props is bound.
`timescale 1ns/100ps
`default_nettype none
`include "cab_defines.vh"

module cab_alu_tb;
	logic        ref_clk = 1'h0;
	logic        rstn = 1'h0;
	logic        clk_en = 1'h1;
	logic        start = 1'h0;
	logic [5:0]  op = 6'h00;
	logic [31:0] dst = 32'h0;
	logic [31:0] src_req = 32'h0;
	logic [31:0] src;
	logic [2:0]  field_idx = 3'h0;
	logic        use_setup_idx = 1'h0;
	logic [2:0]  setup_idx = 3'h0;
	logic        carry_write_suffix = 1'h0;
	logic        zero_write_suffix = 1'h0;
	logic [1:0]  flag_combine = 2'h0;
	logic        done, result_we, next_src_valid, carry_flag, zero_flag;
	logic [31:0] result, next_src;
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;

	always #12.5 ref_clk = ~ref_clk;

	cab_alu dut (.*);
	cab_src_model u_src (.*);

	////////////////////////////////////////////////////////////////////////////////
	task stop_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			stop_test();
		end
	end

	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	// Two idle cycles between ops keep the partner's substitution unambiguous
	task go(input logic [5:0] o, input logic [31:0] d, s, input logic [1:0] f);
		@(posedge ref_clk);
		start <= 1'h1;
		op <= o;
		dst <= d;
		src_req <= s;
		{carry_write_suffix, zero_write_suffix} <= f;
		@(posedge ref_clk);
		start <= 1'h0;
		@(posedge ref_clk);
		#1;
		chk(done, 1'h1);
	endtask

	task ex(input logic [31:0] r, input logic c, z);
		chk(result, r);
		chk(carry_flag, c);
		chk(zero_flag, z);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task t_sub;
		go(`CAB_SUBTRACT_OP, 32'h5, 32'h7, 2'h3); ex(32'hFFFFFFFE, 1'h1, 1'h0);
		go(`CAB_REVERSE_SUBTRACT_OP, 32'h5, 32'h7, 2'h3); ex(32'h2, 1'h0, 1'h0);
		go(`CAB_SIGNED_SUBTRACT_OP, 32'h80000000, 32'h1, 2'h3);
		ex(32'h7FFFFFFF, 1'h1, 1'h0);
		go(`CAB_EXTENDED_SUBTRACT_OP, 32'h8, 32'h7, 2'h3); ex(32'h0, 1'h0, 1'h0);
		go(`CAB_SUBTRACT_OP, 32'h3, 32'h3, 2'h3); ex(32'h0, 1'h0, 1'h1);
		go(`CAB_EXTENDED_SUBTRACT_OP, 32'h9, 32'h9, 2'h3); ex(32'h0, 1'h0, 1'h1);
		go(`CAB_SIGNED_EXTENDED_SUBTRACT_OP, 32'h7FFFFFFF, 32'hFFFFFFFF, 2'h3);
		ex(32'h80000000, 1'h0, 1'h0);
	endtask

	task t_shift;
		go(`CAB_LOGICAL_LEFT_SHIFT_OP, 32'h80000001, 32'h1, 2'h3); ex(32'h2, 1'h1, 1'h0);
		go(`CAB_LOGICAL_LEFT_SHIFT_OP, 32'h80000000, 32'h0, 2'h3);
		ex(32'h80000000, 1'h1, 1'h0);
		go(`CAB_LOGICAL_RIGHT_SHIFT_OP, 32'h3, 32'h21, 2'h3); ex(32'h1, 1'h1, 1'h0);
		go(`CAB_LOGICAL_RIGHT_SHIFT_OP, 32'h2, 32'h0, 2'h3); ex(32'h2, 1'h0, 1'h0);
		go(`CAB_SIGN_EXTEND_OP, 32'h80, 32'h7, 2'h3); ex(32'hFFFFFF80, 1'h1, 1'h0);
		go(`CAB_ZERO_EXTEND_OP, 32'hFFFFFFFF, 32'h7, 2'h3); ex(32'hFF, 1'h0, 1'h0);
	endtask

	task t_ins;
		field_idx <= 3'h2;
		go(`CAB_INSERT_BYTE_OP, 32'h11223344, 32'hAABBCCDD, 2'h0);
		chk(result, 32'h11DD3344);
		chk(result_we, 1'h1);
		field_idx <= 3'h7;
		go(`CAB_INSERT_NIBBLE_OP, 32'h0, 32'hF5, 2'h0); chk(result, 32'h50000000);
		field_idx <= 3'h1;
		go(`CAB_INSERT_HALFWORD_OP, 32'h12345678, 32'hABCD, 2'h0); chk(result, 32'hABCD5678);
		use_setup_idx <= 1'h1;
		setup_idx <= 3'h1;
		field_idx <= 3'h3;
		go(`CAB_INSERT_BYTE_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'hFFFF00FF);
		use_setup_idx <= 1'h0;
		go(`CAB_INSERT_DEST_FIELD_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'hFFFC01FF);
		go(`CAB_INSERT_RESULT_FIELD_OP, 32'h0, 32'hFFFF, 2'h0); chk(result, 32'h0FF80000);
		go(`CAB_INSERT_SOURCE_FIELD_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'hFFFFFE00);
	endtask

	task t_split;
		go(`CAB_SPLIT_TO_BYTES_OP, 32'hF, 32'h0, 2'h0); chk(result, 32'h01010101);
		go(`CAB_SPLIT_TO_BYTES_OP, 32'h11111111, 32'h0, 2'h0); chk(result, 32'hFF);
		go(`CAB_SPLIT_TO_WORDS_OP, 32'hAAAAAAAA, 32'h0, 2'h0); chk(result, 32'hFFFF0000);
		go(`CAB_SPLIT_TO_WORDS_OP, 32'h3, 32'h0, 2'h0); chk(result, 32'h00010001);
	endtask

	task t_scr;
		go(`CAB_SCRAMBLE_FORWARD_OP, 32'h12345678, 32'h0, 2'h0);
		chk(result !== 32'h12345678, 1'h1);
		go(`CAB_SCRAMBLE_REVERSE_OP, result, 32'h0, 2'h0); chk(result, 32'h12345678);
		repeat (32) go(`CAB_SCRAMBLE_FORWARD_OP, result, 32'h0, 2'h0);
		chk(result, 32'h12345678);
	endtask

	task t_feed;
		go(`CAB_SCALE_UNSIGNED_OP, 32'h8000, 32'h8000, 2'h0);
		chk(next_src, 32'h4000);
		chk({next_src_valid, result_we}, 2'h2);
		go(`CAB_SUBTRACT_OP, 32'h5000, 32'h0, 2'h0); chk(result, 32'h1000);
		go(`CAB_SCALE_SIGNED_OP, 32'h4000, 32'hC000, 2'h0); chk(next_src, 32'hFFFFC000);
		go(`CAB_SUBTRACT_OP, 32'h0, 32'h0, 2'h0); chk(result, 32'h4000);
		go(`CAB_RANDOM_STEP_OP, 32'h00000001, 32'h0, 2'h0);
		chk(result, 32'h04002021);
		chk(next_src, 32'h1);
	endtask

	task t_probe;
		go(`CAB_MASK_PROBE_OP, 32'h7, 32'hFFFFFFFF, 2'h3); ex(32'h1, 1'h1, 1'h0);
		go(`CAB_MASK_PROBE_OP, 32'hF0, 32'h0F, 2'h3); chk({carry_flag, zero_flag}, 2'h1);
		go(`CAB_INVERTED_MASK_PROBE_OP, 32'hF0, 32'h0F, 2'h3);
		chk({carry_flag, zero_flag}, 2'h0);
		go(`CAB_BIT_PROBE_OP, 32'h4, 32'h2, 2'h2); chk(carry_flag, 1'h1);
		flag_combine <= 2'h2;
		go(`CAB_INVERTED_BIT_PROBE_OP, 32'h4, 32'h2, 2'h2); chk(carry_flag, 1'h0);
		flag_combine <= 2'h1;
		go(`CAB_BIT_PROBE_OP, 32'h4, 32'h2, 2'h2); chk(carry_flag, 1'h1);
		flag_combine <= 2'h3;
		go(`CAB_BIT_PROBE_OP, 32'h4, 32'h2, 2'h2); chk(carry_flag, 1'h0);
		flag_combine <= 2'h0;
		go(`CAB_INVERTED_BIT_PROBE_OP, 32'h0, 32'h5, 2'h1); ex(32'h0, 1'h0, 1'h1);
		go(`CAB_STORE_CARRY_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'h0);
		go(`CAB_STORE_NOT_CARRY_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'h1);
		go(`CAB_STORE_ZERO_FLAG_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'h1);
		go(`CAB_STORE_NOT_ZERO_FLAG_OP, 32'hFFFFFFFF, 32'h0, 2'h0); chk(result, 32'h0);
		go(`CAB_XOR_OP, 32'hF0F0, 32'h0F0E, 2'h3); ex(32'hFFFE, 1'h1, 1'h0);
	endtask

	task t_sum;
		go(`CAB_COND_SUM_ON_CARRY_OP, 32'hA, 32'h3, 2'h3); ex(32'h7, 1'h0, 1'h0);
		go(`CAB_COND_SUM_ON_CARRY_OP, 32'hA, 32'h3, 2'h3); ex(32'hD, 1'h0, 1'h0);
		go(`CAB_COND_SUM_ON_ZERO_OP, 32'hA, 32'h3, 2'h3); ex(32'hD, 1'h0, 1'h0);
		go(`CAB_COND_SUM_ON_NONZERO_OP, 32'hA, 32'h3, 2'h3); ex(32'h7, 1'h0, 1'h0);
		go(`CAB_COND_SUM_ON_NOCARRY_OP, 32'h0, 32'h1, 2'h3); ex(32'hFFFFFFFF, 1'h1, 1'h0);
		go(`CAB_COND_SUM_ON_CARRY_OP, 32'h80000000, 32'h1, 2'h3);
		ex(32'h7FFFFFFF, 1'h1, 1'h0);
		go(`CAB_SUBTRACT_OP, 32'h0, 32'h1, 2'h0); ex(32'hFFFFFFFF, 1'h1, 1'h0);
		go(`CAB_SUBTRACT_OP, 32'h1, 32'h1, 2'h1); ex(32'h0, 1'h1, 1'h1);
	endtask

	// Take, then freeze: nothing may complete while clk_en is low
	task t_freeze;
		@(posedge ref_clk);
		start <= 1'h1;
		op <= `CAB_XOR_OP;
		dst <= 32'h1;
		src_req <= 32'h2;
		@(posedge ref_clk);
		start <= 1'h0;
		clk_en <= 1'h0;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(done, 1'h0);
		clk_en <= 1'h1;
		@(posedge ref_clk);
		#1;
		chk({done, result}, {1'h1, 32'h3});
	endtask

	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		chk(result | next_src, 32'h0);
		chk({done, result_we, next_src_valid, carry_flag, zero_flag}, 32'h0);
		rstn <= 1'h1;
		t_sub();
		t_shift();
		t_ins();
		t_split();
		t_scr();
		t_feed();
		t_probe();
		t_sum();
		t_freeze();
		stop_test();
	end
endmodule
`default_nettype wire
